// [hw/smac_dev.sv]
/*
 device end: protocol choice, answer to reset, security modes, password and
 authentication state, zone write policy.
 assumes link inputs come from another domain; link clock, reset and command strobe are synchronised here.
*/
`timescale 1ns/1ns
module smac_dev
   import smac_pkg::*;
(
   input wire logic core_clk_i,  // core clock
   input wire logic rst_i,  // power-on reset, async high
   smac_if.dev lnk,  // link to host
   input wire logic [4:0] zone_pol_i,  // selected zone policy bits
   input wire logic [7:0] mem_old_i,  // stored byte at target
   input wire logic [7:0] lock_mask_i,  // page lock mask byte
   input wire logic super_en_i,  // supervisor feature on
   input wire logic tear_pending_i,  // buffer holds unfinished write
   output logic [7:0] mem_wdata_o,  // byte to commit
   output logic mem_we_o,  // commit strobe
   output logic buf_we_o,  // write to buffer zone first
   output logic restore_o,  // restore from buffer zone
   output smac_proto_type proto_o,  // chosen protocol
   output smac_sec_type sec_o,  // security mode
   output logic [3:0] pw_set_o,  // active password set, bit3 = write
   output logic pw_vld_o,  // password in force
   output logic super_o,  // supervisor access granted
   output logic [15:0] etu_o  // carrier periods per bit
);
   typedef struct packed {
      logic [1:0] clk_s;  // link clock sync
      logic [1:0] rst_s;  // reset sync
      logic [1:0] vld_s;  // command sync
      logic clk_d;  // last link clock
      logic vld_d;  // last command level
      smac_proto_type proto;  // protocol
      logic started;  // first link clock rise seen
      logic [5:0] atr_idx;  // answer bit index
      logic atr_busy;  // answer in progress
      logic [15:0] etu_cnt;  // carrier count in bit
      logic [15:0] etu;  // bit length
      smac_sec_type sec;  // security mode
      logic [3:0] pw_set;  // password set
      logic pw_vld;  // password valid
      logic super_g;  // supervisor granted
      logic [2:0] pw_fail;  // password failures
      logic [2:0] au_fail;  // auth failures
      logic [7:0] wdata;  // commit data
      logic we;  // commit strobe
      logic bwe;  // buffer strobe
      logic restore;  // restore strobe
      logic sda_oe_n;  // data pull
      logic [7:0] rdata;  // answer byte
      logic ack;  // answer level
   } smac_dev_state_type;
   smac_dev_state_type st, next_st;
   logic clk_rise;  // link clock rising edge
   logic cmd_new;  // new command seen
   logic [7:0] wr;  // write byte after policy
   logic wr_ok;  // write allowed
   logic lock_zone;  // zone is write lock
   logic [2:0] bsel;  // byte within page
   assign clk_rise = st.clk_s[1] & ~st.clk_d;
   assign cmd_new = st.vld_s[1] & ~st.vld_d;
   assign lock_zone = (zone_pol_i & ZP_LOCK) != 5'h00;
   assign bsel = lnk.arg[10:8];
   // write policy on the target byte
   always_comb
   begin
      wr = lnk.arg[7:0];  // first data byte only
      wr_ok = 1'b1;
      if ((zone_pol_i & ZP_FORBID) != 5'h00)
         wr_ok = 1'b0;
      if ((zone_pol_i & ZP_ENC) != 5'h00 && st.sec != SEC_ENC)
         wr_ok = 1'b0;
      if ((zone_pol_i & ZP_PROG) != 5'h00)
         wr = wr & mem_old_i;
      // mask byte may only clear, locked by its bit0
      if (lock_zone && bsel == 3'd0)
      begin
         wr = wr & lock_mask_i;
         if ((lock_mask_i & LOCK_BIT0) == 8'h00)
            wr_ok = 1'b0;
      end
      else if (lock_zone && lock_mask_i[bsel] == 1'b0)
         wr_ok = 1'b0;
      if ((zone_pol_i & ZP_AT) != 5'h00 && lnk.arg[31:28] > 4'(AT_MAX_BYTES - 1))
         wr_ok = 1'b0;
   end
   // next state
   always_comb
   begin
      next_st = st;
      next_st.clk_s = {st.clk_s[0], lnk.link_clk};
      next_st.rst_s = {st.rst_s[0], lnk.link_rst};
      next_st.vld_s = {st.vld_s[0], lnk.op_vld};
      next_st.clk_d = st.clk_s[1];
      next_st.vld_d = st.vld_s[1];
      next_st.we = st.bwe;  // destination write follows the buffer write
      next_st.bwe = 1'b0;
      next_st.restore = 1'b0;
      // protocol choice at first link clock rise, reset sync settled by then
      if (!st.started && clk_rise)
      begin
         next_st.started = 1'b1;
         next_st.restore = tear_pending_i;
         if (st.rst_s[1])
         begin
            next_st.proto = PROTO_SYNC;
         end
         else
         begin
            next_st.proto = PROTO_ASYNC;
         end
      end
      // reset line low clears session state
      if (!st.rst_s[1] && st.started)
      begin
         next_st.proto = PROTO_ASYNC;
         next_st.sec = SEC_STD;
         next_st.pw_vld = 1'b0;
         next_st.super_g = 1'b0;
         next_st.atr_busy = 1'b1;
         next_st.atr_idx = 6'd0;
         next_st.etu_cnt = 16'h0000;
         next_st.etu = 16'(ETU_DEFAULT);
      end
      else if (st.atr_busy && clk_rise)
      begin
         // answer to reset bits, one per bit time
         next_st.sda_oe_n = ATR_CODE[6'd63 - st.atr_idx];
         if (st.etu_cnt == st.etu - 16'h0001)
         begin
            next_st.etu_cnt = 16'h0000;
            next_st.atr_idx = st.atr_idx + 6'd1;
            if (st.atr_idx == 6'd63)
            begin
               next_st.atr_busy = 1'b0;
            end
         end
         else
         begin
            next_st.etu_cnt = st.etu_cnt + 16'h0001;
         end
      end
      else if (!st.atr_busy)
      begin
         next_st.sda_oe_n = 1'b1;
      end
      // commands
      if (cmd_new && !st.atr_busy)
      begin
         next_st.ack = 1'b1;
         case (lnk.op)
            OP_PW:
            begin
               if (st.pw_fail >= 3'(FAIL_LIMIT))
                  next_st.ack = 1'b0;
               else if (lnk.arg[8])
               begin
                  next_st.pw_set = lnk.arg[3:0];
                  next_st.pw_vld = 1'b1;
                  next_st.pw_fail = 3'd0;
                  next_st.super_g = super_en_i & lnk.arg[9];
               end
               else
               begin
                  next_st.pw_vld = 1'b0;
                  next_st.super_g = 1'b0;
                  next_st.pw_fail = st.pw_fail + 3'd1;
               end
            end
            OP_AUTH:
            begin
               if (st.au_fail >= 3'(FAIL_LIMIT))
                  next_st.ack = 1'b0;
               else
               begin
                  next_st.sec = lnk.arg[8] ? SEC_AUTH : SEC_STD;
                  next_st.au_fail = lnk.arg[8] ? 3'd0 : st.au_fail + 3'd1;
               end
            end
            OP_ENC:
               if (st.sec != SEC_STD)
                  next_st.sec = SEC_ENC;
            OP_MACERR:
            begin
               next_st.sec = SEC_STD;
               next_st.ack = 1'b0;
            end
            OP_PPS:
            begin
               if (smac_pps_ok(lnk.arg[9:0], lnk.arg[14:10]))
                  next_st.etu = 16'(lnk.arg[9:0] / lnk.arg[14:10]);
               else
                  next_st.ack = 1'b0;
            end
            OP_WRITE:
            begin
               // anti-tearing zones commit one cycle after the buffer write
               next_st.ack = wr_ok;
               next_st.wdata = wr;
               next_st.bwe = wr_ok & ((zone_pol_i & ZP_AT) != 5'h00);
               next_st.we = wr_ok & ((zone_pol_i & ZP_AT) == 5'h00);
            end
            OP_READ:
            begin
               if ((zone_pol_i & ZP_ENC) != 5'h00 && st.sec != SEC_ENC)
                  next_st.ack = 1'b0;
               else  // encryption mode marks data as ciphered
                  next_st.rdata = (st.sec == SEC_ENC) ? ~mem_old_i : mem_old_i;
            end
            default:
               next_st.ack = 1'b0;
         endcase
      end
   end
   // state register
   always_ff @(posedge core_clk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         st <= '0;
         st.sda_oe_n <= 1'b1;
         st.etu <= 16'(ETU_DEFAULT);
      end
      else
      begin
         st <= next_st;
      end
   end
   assign lnk.dev_sda_oe_n = st.sda_oe_n;
   assign lnk.rdata = st.rdata;
   assign lnk.ack = st.ack;
   assign mem_wdata_o = st.wdata;
   assign mem_we_o = st.we;
   assign buf_we_o = st.bwe;
   assign restore_o = st.restore;
   assign proto_o = st.proto;
   assign sec_o = st.sec;
   assign pw_set_o = st.pw_set;
   assign pw_vld_o = st.pw_vld;
   assign super_o = st.super_g;
   assign etu_o = st.etu;
endmodule

// [hw/smac_pkg.sv]
/*
 shared constants and types of the secure memory access control link:
 power-up protocol choice, security modes, zone policies, timing counts.
 assumes a 10 MHz core clock on both ends.
*/
package smac_pkg;
   localparam int CORE_CLK_HZ = 10_000_000;  // core clock rate
   localparam int COLD_CLK_CYCLES = 400;  // link clocks before reset rises
   localparam int SYNC_WAKE_PULSES = 5;  // clocks before first sync command
   localparam int ETU_DEFAULT = 372;  // carrier periods per bit
   localparam int AT_MAX_BYTES = 8;  // anti-tearing payload limit
   localparam int FAIL_LIMIT = 4;  // consecutive failures allowed
   localparam int POLL_WRITE_MS = 20;  // ack poll after write
   localparam int POLL_PWRUP_MS = 10;  // ack poll at power-up
   localparam int POLL_WRITE_CYC = POLL_WRITE_MS * (CORE_CLK_HZ / 1000);
   localparam int POLL_PWRUP_CYC = POLL_PWRUP_MS * (CORE_CLK_HZ / 1000);
   localparam int LINK_DIV = 4;  // host core cycles per link clock half
   localparam logic [7:0] ATR_HIST = 8'h64;  // density byte, arbitrary value
   localparam logic [63:0] ATR_CODE = 64'h3B00_0000_0000_0064;  // arbitrary
   localparam logic [7:0] LOCK_BIT0 = 8'h01;  // mask byte self lock bit
   localparam logic [4:0] ZP_FORBID = 5'h01;  // zone policy: modify forbidden
   localparam logic [4:0] ZP_PROG = 5'h02;  // zone policy: program only
   localparam logic [4:0] ZP_LOCK = 5'h04;  // zone policy: write lock
   localparam logic [4:0] ZP_ENC = 5'h08;  // zone policy: encryption required
   localparam logic [4:0] ZP_AT = 5'h10;  // policy: anti-tearing on
   typedef enum logic [1:0] {SEC_STD, SEC_AUTH, SEC_ENC} smac_sec_type;
   typedef enum logic [1:0] {PROTO_NONE, PROTO_ASYNC, PROTO_SYNC} smac_proto_type;
   typedef enum logic [3:0] {
      OP_NOP, OP_PW, OP_AUTH, OP_ENC, OP_WRITE, OP_READ, OP_PPS, OP_MACERR
   } smac_op_type;
   // speed negotiation check
   function automatic logic smac_pps_ok(input logic [9:0] f, input logic [4:0] d);
      smac_pps_ok = (f == 10'd372 && (d == 5'd1 || d == 5'd2 || d == 5'd4 ||
         d == 5'd8 || d == 5'd12 || d == 5'd16)) ||
         (f == 10'd512 && (d == 5'd8 || d == 5'd16));
   endfunction
endpackage

// [hw/smac_if.sv]
/*
 link between host and secure memory: clock, reset, open-drain data,
 and a command word bundle standing for the serial command decode.
 the data wire is resolved here from the two enables.
*/
`timescale 1ns/1ns
interface smac_if;
   import smac_pkg::*;
   logic link_clk;  // host made link clock
   logic link_rst;  // card reset line, high default
   logic host_sda_oe_n;  // host pulls data low when low
   logic dev_sda_oe_n;  // device pulls data low when low
   logic sda;  // resolved wire level
   smac_op_type op;  // decoded command
   logic op_vld;  // command toggle-free level strobe, held until the second link clock rise
   logic [31:0] arg;  // command argument
   logic [7:0] rdata;  // device answer byte
   logic ack;  // device answer level
   assign sda = host_sda_oe_n & dev_sda_oe_n;
   modport host (output link_clk, link_rst, host_sda_oe_n, op, op_vld, arg,
      input sda, rdata, ack);
   modport dev (input link_clk, link_rst, host_sda_oe_n, op, op_vld, arg, sda,
      output dev_sda_oe_n, rdata, ack);
endinterface

// [hw/smac_host.sv]
/*
 host end: makes the link clock by a divider, runs the cold start or sync
 wake-up sequence, then issues one command at a time.
 assumes commands come from local logic on the core clock.
*/
`timescale 1ns/1ns
module smac_host
   import smac_pkg::*;
(
   input wire logic core_clk_i,  // core clock
   input wire logic rst_i,  // async reset, high
   smac_if.host lnk,  // link to device
   input wire logic async_i,  // choose async cold start
   input wire logic cmd_vld_i,  // command request
   input wire smac_op_type cmd_op_i,  // command
   input wire logic [31:0] cmd_arg_i,  // argument
   output logic cmd_rdy_o,  // ready for command
   output logic ready_o,  // start-up done
   output logic poll_o  // ack poll window open
);
   typedef enum {H_START, H_WAKE, H_IDLE, H_CMD, H_POLL} smac_hstate_type;
   typedef struct packed {
      smac_hstate_type fsm;  // sequence state
      logic [2:0] div;  // clock divider
      logic clk;  // link clock
      logic rst;  // reset line
      logic [9:0] cnt;  // link clock count
      logic [31:0] poll;  // poll timer
      logic vld;  // command level
      smac_op_type op;  // command
      logic [31:0] arg;  // argument
   } smac_host_state_type;
   smac_host_state_type st, next_st;
   logic edge_up;  // link clock rises this cycle
   assign edge_up = (st.div == 3'(LINK_DIV - 1)) & ~st.clk;
   // sequence
   always_comb
   begin
      next_st = st;
      next_st.div = (st.div == 3'(LINK_DIV - 1)) ? 3'd0 : st.div + 3'd1;
      if (st.div == 3'(LINK_DIV - 1))
      begin
         next_st.clk = ~st.clk;
      end
      if (st.poll != 32'h0000_0000)
      begin
         next_st.poll = st.poll - 32'h0000_0001;
      end
      case (st.fsm)
         H_START:
         begin
            next_st.rst = ~async_i;
            next_st.fsm = H_WAKE;
            next_st.cnt = 10'd0;
         end
         H_WAKE:
         begin
            if (edge_up)
            begin
               next_st.cnt = st.cnt + 10'd1;
               // card reset rises only after the full count of link clocks
               if (async_i && st.cnt == 10'(COLD_CLK_CYCLES))
               begin
                  next_st.rst = 1'b1;
                  next_st.fsm = H_IDLE;
               end
               else if (!async_i && st.cnt == 10'(SYNC_WAKE_PULSES - 1))
               begin
                  next_st.fsm = H_IDLE;
                  next_st.poll = 32'(POLL_PWRUP_CYC);
               end
            end
         end
         H_IDLE:
         begin
            if (cmd_vld_i)
            begin
               next_st.op = cmd_op_i;
               next_st.arg = cmd_arg_i;
               next_st.vld = 1'b1;
               next_st.cnt = 10'd0;
               next_st.fsm = H_CMD;
            end
         end
         H_CMD:
         begin
            // hold command level long enough for the device to see it
            if (edge_up)
            begin
               next_st.cnt = st.cnt + 10'd1;
               if (st.cnt == 10'd1)
               begin
                  next_st.vld = 1'b0;
                  next_st.fsm = (st.op == OP_WRITE) ? H_POLL : H_IDLE;
                  if (st.op == OP_WRITE)
                  begin
                     next_st.poll = 32'(POLL_WRITE_CYC);
                  end
               end
            end
         end
         H_POLL:
         begin
            if (lnk.ack || st.poll == 32'h0000_0000)
            begin
               next_st.fsm = H_IDLE;
            end
         end
         default:
         begin
            next_st.fsm = H_START;
         end
      endcase
   end
   // state register
   always_ff @(posedge core_clk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         st <= '0;
      end
      else
      begin
         st <= next_st;
      end
   end
   assign lnk.link_clk = st.clk;
   assign lnk.link_rst = st.rst;
   assign lnk.host_sda_oe_n = 1'b1;  // receive mode
   assign lnk.op = st.op;
   assign lnk.op_vld = st.vld;
   assign lnk.arg = st.arg;
   assign cmd_rdy_o = (st.fsm == H_IDLE);
   assign ready_o = (st.fsm != H_START) && (st.fsm != H_WAKE);
   assign poll_o = (st.poll != 32'h0000_0000);
endmodule

// [test/smac_assertions.sv]
/*
 concurrent checks on the host-device link of the secure memory pair.
 assumes the bench's core clock and power reset, and link signals from smac_if.
*/
`timescale 1ns/1ns
module smac_assertions
   import smac_pkg::*;
(
   input wire logic core_clk_i,  // core clock
   input wire logic rst_i,  // power reset, high
   input wire logic link_clk,  // link clock
   input wire logic link_rst,  // card reset line
   input wire logic host_sda_oe_n,  // host pull, low drives
   input wire logic dev_sda_oe_n,  // device pull, low drives
   input wire smac_op_type op,  // command word
   input wire logic op_vld,  // command flag
   input wire logic [31:0] arg  // command argument
);
   // helper state: link clock rises, cycles since reset
   typedef struct packed {
      logic lclk_q;  // last link clock level
      logic [9:0] n_rise;  // saturating rise count
      logic [3:0] n_since;  // saturating cycle count
   } smac_chk_type;
   smac_chk_type hs;  // registered helper state
   smac_chk_type next_hs;  // next helper state
   // count edges; saturate so long runs never wrap
   always_comb
   begin
      next_hs = hs;
      next_hs.lclk_q = link_clk;
      if (link_clk && !hs.lclk_q && hs.n_rise != 10'h3ff)
         next_hs.n_rise = hs.n_rise + 10'h001;
      if (hs.n_since != 4'hf)
         next_hs.n_since = hs.n_since + 4'h1;
   end
   // register helper state
   always_ff @(posedge core_clk_i or posedge rst_i)
      if (rst_i)
         hs <= '0;
      else
         hs <= next_hs;
   default clocking cb @(posedge core_clk_i);
   endclocking
   default disable iff (rst_i);
   chk_cold_clocks: assert property ($rose(link_rst) && hs.n_since > 4'h4 |->
      hs.n_rise >= 10'h190) else $error("card reset rose before enough link clocks");
   chk_recv_in_rst: assert property (!link_rst |-> host_sda_oe_n)
      else $error("host drove data while card reset low");
   chk_wake_pulses: assert property ($rose(op_vld) |-> hs.n_rise >= 10'h005)
      else $error("command before wake-up clocks");
   chk_clk_half: assert property ($rose(link_clk) |-> link_clk [*4])
      else $error("link clock high phase too short");
   chk_cmd_stable: assert property ($rose(op_vld) |=> ($stable(op) && $stable(arg)) [*8])
      else $error("command changed while flagged");
   chk_cmd_reset: assert property ($rose(op_vld) |-> link_rst)
      else $error("command while card reset low");
   chk_atr_quiet: assert property (!link_rst [*4] |-> dev_sda_oe_n)
      else $error("device drove data during card reset");
   chk_bit_length: assert property ($fell(dev_sda_oe_n) |=> !dev_sda_oe_n [*4])
      else $error("device data bit too short");
   cov_cmd: cover property ($rose(op_vld));
   cov_atr: cover property ($fell(dev_sda_oe_n));
   cov_cold: cover property ($rose(link_rst) && hs.n_since > 4'h4);
endmodule

// [test/tb_top.sv]
/*
 self-checking bench: host and device joined by smac_if, scenario tasks.
 assumes 10 MHz core clock, package constants, no other stimulus.
*/
`timescale 1ns/1ns
module tb_top;
   import smac_pkg::*;
   typedef struct {
      logic [4:0] pol;
      logic [7:0] old;
      logic [7:0] mask;
      logic [31:0] arg;
      int nwe;
      int nbwe;
      logic [7:0] wd;
   } smac_case_type;
   logic core_clk, rst, async, cmd_vld, sup_en, tear;  // driven inputs
   smac_op_type cmd_op;  // host command
   logic [31:0] cmd_arg;  // host argument
   logic [4:0] zpol;  // zone policy
   logic [7:0] mold, lmask;  // stored byte, lock mask
   logic [7:0] wdata;  // committed byte
   logic we, bwe, rest, pwv, supo, rdy, ready, poll;  // design flags
   smac_proto_type proto;  // chosen protocol
   smac_sec_type sec;  // security mode
   logic [3:0] pwset;  // password set
   logic [15:0] etu;  // bit time
   int n_mismatch, compares, n_we, n_bwe, n_rest;  // counters
   logic [7:0] last_wd;  // last committed byte
   smac_if u_if();
   smac_host u_smac_host(.core_clk_i(core_clk), .rst_i(rst), .lnk(u_if), .async_i(async),
      .cmd_vld_i(cmd_vld), .cmd_op_i(cmd_op), .cmd_arg_i(cmd_arg), .cmd_rdy_o(rdy),
      .ready_o(ready), .poll_o(poll));
   smac_dev u_smac_dev(.core_clk_i(core_clk), .rst_i(rst), .lnk(u_if), .zone_pol_i(zpol),
      .mem_old_i(mold), .lock_mask_i(lmask), .super_en_i(sup_en), .tear_pending_i(tear),
      .mem_wdata_o(wdata), .mem_we_o(we), .buf_we_o(bwe), .restore_o(rest), .proto_o(proto),
      .sec_o(sec), .pw_set_o(pwset), .pw_vld_o(pwv), .super_o(supo), .etu_o(etu));
   smac_assertions u_smac_assertions(.core_clk_i(core_clk), .rst_i(rst),
      .link_clk(u_if.link_clk), .link_rst(u_if.link_rst), .host_sda_oe_n(u_if.host_sda_oe_n),
      .dev_sda_oe_n(u_if.dev_sda_oe_n), .op(u_if.op), .op_vld(u_if.op_vld), .arg(u_if.arg));
   // core clock
   initial
   begin
      core_clk = 1'b0;
      forever #50 core_clk = ~core_clk;
   end
   // count one-cycle pulses of the device
   always @(posedge core_clk)
      if (rst)
      begin
         n_we <= 0;
         n_bwe <= 0;
         n_rest <= 0;
      end
      else
      begin
         n_we <= n_we + int'(we);
         n_bwe <= n_bwe + int'(bwe);
         n_rest <= n_rest + int'(rest);
         if (we)
            last_wd <= wdata;
      end
   task finish_test;
      if (n_mismatch == 0 && compares > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask
   task cmp(input string what, input logic [15:0] exp, input logic [15:0] got);
      compares++;
      if (got !== exp)
      begin
         n_mismatch++;
         $display("wrong value %s expected %h seen %h", what, exp, got);
      end
   endtask
   task expire(input string what);
      n_mismatch++;
      $display("wrong value %s expected done seen timeout", what);
      finish_test();
   endtask
   // power reset; async waits for the first answer bit, sync for ready
   task do_reset(input logic asy);
      int i;
      rst <= 1'b1;
      async <= asy;
      repeat (12) @(posedge core_clk);
      rst <= 1'b0;
      i = 0;
      do @(negedge core_clk); while (!(asy ? !u_if.dev_sda_oe_n : ready) && ++i < 8000);
      if (i == 8000)
         expire("start-up");
   endtask
   // one command; held until taken
   task send(input smac_op_type op, input logic [31:0] arg);
      int i;
      @(posedge core_clk);
      cmd_op <= op;
      cmd_arg <= arg;
      cmd_vld <= 1'b1;
      i = 0;
      do @(negedge core_clk); while (!rdy && ++i < 4000);
      if (!rdy)
         expire("command taken");
      @(posedge core_clk);
      cmd_vld <= 1'b0;
      repeat (30) @(posedge core_clk);
   endtask
   task t_async;
      do_reset(1'b1);
      cmp("protocol", 16'(PROTO_ASYNC), 16'(proto));
      cmp("poll window", 16'h0000, 16'(poll));
      repeat (2000) @(posedge core_clk);
      cmp("protocol kept", 16'(PROTO_ASYNC), 16'(proto));
   endtask
   task t_modes;
      mold <= 8'h3c;
      do_reset(1'b0);
      cmp("protocol", 16'(PROTO_SYNC), 16'(proto));
      cmp("mode", 16'(SEC_STD), 16'(sec));
      cmp("bit time", 16'(ETU_DEFAULT), etu);
      cmp("restores", 16'h0000, 16'(n_rest));
      cmp("power-up poll", 16'h0001, 16'(poll));
      send(OP_READ, 32'h0000_0000);
      cmp("read data", 16'h003c, {8'h00, u_if.rdata});
      send(OP_ENC, 32'h0000_0100);
      cmp("mode", 16'(SEC_STD), 16'(sec));
      send(OP_AUTH, 32'h0000_0100);
      cmp("mode", 16'(SEC_AUTH), 16'(sec));
      send(OP_ENC, 32'h0000_0100);
      cmp("mode", 16'(SEC_ENC), 16'(sec));
      send(OP_READ, 32'h0000_0000);
      cmp("read data", 16'h00c3, {8'h00, u_if.rdata});
      send(OP_MACERR, 32'h0000_0000);
      cmp("mode", 16'(SEC_STD), 16'(sec));
      send(OP_AUTH, 32'h0000_0100);
      send(OP_AUTH, 32'h0000_0000);
      cmp("mode", 16'(SEC_STD), 16'(sec));
   endtask
   task t_password;
      sup_en <= 1'b1;
      do_reset(1'b0);
      send(OP_PW, 32'h0000_0105);
      cmp("password held", 16'h0001, 16'(pwv));
      cmp("password set", 16'h0005, 16'(pwset));
      send(OP_PW, 32'h0000_010b);
      cmp("password set", 16'h000b, 16'(pwset));
      send(OP_PW, 32'h0000_0300);
      cmp("supervisor", 16'h0001, 16'(supo));
      repeat (4) send(OP_PW, 32'h0000_0002);
      cmp("password held", 16'h0000, 16'(pwv));
      send(OP_PW, 32'h0000_0105);
      cmp("answer", 16'h0000, 16'(u_if.ack));
      cmp("password held", 16'h0000, 16'(pwv));
      sup_en <= 1'b0;
   endtask
   // every listed rate pair, then two outside the list
   task t_pps;
      int f [10] = '{372, 372, 372, 372, 372, 372, 512, 512, 512, 372};
      int d [10] = '{1, 2, 4, 8, 12, 16, 8, 16, 4, 3};
      int e;
      e = ETU_DEFAULT;
      for (int i = 0; i < 10; i++)
      begin
         send(OP_PPS, {17'h0_0000, 5'(d[i]), 10'(f[i])});
         if (i < 8)
            e = f[i] / d[i];
         cmp("bit time", 16'(e), etu);
      end
   endtask
   // zone policies; a fresh power-up per case so refused writes cannot stall
   task t_write;
      smac_case_type cs [10] = '{
         '{5'h00, 8'h00, 8'hff, 32'h0000_00a5, 1, 0, 8'ha5},
         '{ZP_FORBID, 8'h00, 8'hff, 32'h0000_00a5, 0, 0, 8'h00},
         '{ZP_PROG, 8'h0f, 8'hff, 32'h0000_00f3, 1, 0, 8'h03},
         '{ZP_LOCK, 8'h00, 8'hd9, 32'h0000_0122, 0, 0, 8'h00},
         '{ZP_LOCK, 8'h00, 8'hd9, 32'h7000_035a, 1, 0, 8'h5a},
         '{ZP_LOCK, 8'hd8, 8'hd8, 32'h0000_0011, 0, 0, 8'h00},
         '{ZP_LOCK, 8'hd9, 8'hd9, 32'h0000_00ff, 1, 0, 8'hd9},
         '{ZP_AT, 8'h00, 8'hff, 32'h7000_0011, 1, 1, 8'h11},
         '{ZP_AT, 8'h00, 8'hff, 32'h8000_0011, 0, 0, 8'h00},
         '{ZP_ENC, 8'h00, 8'hff, 32'h0000_0011, 0, 0, 8'h00}};
      for (int i = 0; i < 10; i++)
      begin
         zpol <= cs[i].pol;
         mold <= cs[i].old;
         lmask <= cs[i].mask;
         do_reset(1'b0);
         send(OP_WRITE, cs[i].arg);
         cmp("commits", 16'(cs[i].nwe), 16'(n_we));
         cmp("buffer writes", 16'(cs[i].nbwe), 16'(n_bwe));
         if (cs[i].nwe > 0)
            cmp("commit byte", {8'h00, cs[i].wd}, {8'h00, last_wd});
      end
      zpol <= 5'h00;
   endtask
   task t_restore;
      tear <= 1'b1;
      do_reset(1'b0);
      cmp("restores", 16'h0001, 16'(n_rest));
      tear <= 1'b0;
   endtask
   // main sequence
   initial
   begin
      rst = 1'b1;
      async = 1'b0;
      cmd_vld = 1'b0;
      cmd_op = OP_NOP;
      cmd_arg = 32'h0000_0000;
      zpol = 5'h00;
      mold = 8'h00;
      lmask = 8'hff;
      sup_en = 1'b0;
      tear = 1'b0;
      n_mismatch = 0;
      compares = 0;
      last_wd = 8'h00;
      t_async();
      t_modes();
      t_password();
      t_pps();
      t_write();
      t_restore();
      finish_test();
   end
endmodule
